// file: pfa_table_access.sv
`timescale 1ns/1ps
`default_nettype none
module pfa_table_access
   import pfa_pkg::*;
#(
   parameter int ARRAY_WORDS = PFA_ARRAY_WORDS_DFLT
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire pfa_tbl_req_t tblReq,
   output logic tblReady,
   output pfa_tbl_rsp_t tblRsp,
   output logic busy,
   output logic opDone,
   input wire logic pgClk,
   input wire logic pgDataIn,
   output logic pgDataOut,
   output logic pgDataOe,
   input wire logic mclrN
);
   localparam int AW = $clog2(ARRAY_WORDS);
   localparam int LW = $clog2(PFA_ROW_WORDS);
   localparam int CW = $clog2(PFA_ERASE_WORDS) + 1;
   localparam int EW = $clog2(PFA_ERASE_WORDS);
   localparam logic [CW-1:0] ROW_END = CW'(PFA_ROW_WORDS);
   localparam logic [CW-1:0] ERASE_END = CW'(PFA_ERASE_WORDS - 1);

   pfa_state_t stateQ, stateD;
   logic [CW-1:0] cntQ;
   logic [AW-1:0] baseQ;
   logic rdSerQ, rdHighQ, rdByteQ, rdOddQ;
   logic tblReadyQ, busyQ, opDoneQ;
   pfa_tbl_rsp_t tblRspQ;
   // Serial side
   logic pgClkQ, serPendQ, frameDone;
   logic [5:0] serCntQ;
   logic [PFA_FRAME_BITS-1:0] serShiftQ;
   pfa_ser_frame_t serFrameQ;
   logic [PFA_WORD_W-1:0] outShiftQ;
   logic [4:0] outCntQ;
   logic pgDataOutQ, pgDataOeQ;
   logic pgRise;
   // Unified request
   logic take;
   pfa_op_t reqOp;
   logic [PFA_ADDR_W-1:0] reqAddr;
   logic [PFA_WORD_W-1:0] reqData;
   logic [2:0] reqLanes;
   logic [AW-1:0] wordIdx;
   // Memory ports
   logic [2:0] latchWe, arrWe;
   logic [AW-1:0] arrWaddr;
   logic [PFA_WORD_W-1:0] arrWdata, latchRd, arrRd;

   // Serial frame wins over the core; it only arrives while master clear is held
   always_comb begin
      take = (stateQ == PFA_ST_IDLE) && (serPendQ || (tblReq.valid && tblReadyQ));
      reqLanes = PFA_LANE_NONE;
      if (serPendQ) begin
         reqOp = serFrameQ.op;
         reqAddr = serFrameQ.addr;
         reqData = serFrameQ.data;
         reqLanes = PFA_LANE_ALL;
      end else begin
         reqOp = tblReq.op;
         reqAddr = {tblReq.page, tblReq.ea};
         // Byte data is copied onto every lane; enables choose the one written
         reqData = {tblReq.wdata[7:0], tblReq.byteMode ? {2{tblReq.wdata[7:0]}} : tblReq.wdata};
         if (!tblReq.high) begin
            if (tblReq.byteMode) begin
               reqLanes = tblReq.ea[0] ? PFA_LANE_B1 : PFA_LANE_B0;
            end else begin
               reqLanes = PFA_LANE_LOW;
            end
         end else begin
            // high half lane, odd byte is phantom
            reqLanes = (tblReq.byteMode && tblReq.ea[0]) ? PFA_LANE_NONE : PFA_LANE_HIGH;
         end
      end
      wordIdx = reqAddr[AW:1];
   end

   // Sequencer next state
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         PFA_ST_IDLE: begin
            if (take) begin
               case (reqOp)
                  PFA_OP_READ: stateD = PFA_ST_READ;
                  PFA_OP_PROG: stateD = PFA_ST_PROG;
                  PFA_OP_ERASE: stateD = PFA_ST_ERASE;
                  default: stateD = PFA_ST_IDLE;
               endcase
            end
         end
         PFA_ST_READ: stateD = PFA_ST_IDLE;
         PFA_ST_PROG: begin
            if (cntQ == ROW_END) begin
               stateD = PFA_ST_IDLE;
            end
         end
         PFA_ST_ERASE: begin
            if (cntQ == ERASE_END) begin
               stateD = PFA_ST_IDLE;
            end
         end
         default: stateD = PFA_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stateQ <= PFA_ST_IDLE;
      end else begin
         stateQ <= stateD;
      end
   end

   // Block base and step counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         baseQ <= '0;
         cntQ <= '0;
      end else if (take) begin
         cntQ <= '0;
         if (reqOp == PFA_OP_ERASE) begin
            baseQ <= {wordIdx[AW-1:EW], {EW{1'b0}}};
         end else begin
            baseQ <= {wordIdx[AW-1:LW], {LW{1'b0}}};
         end
      end else if (stateQ == PFA_ST_PROG || stateQ == PFA_ST_ERASE) begin
         cntQ <= cntQ + CW'(1);
      end
   end

   // writes only reach latches by write op, core or serial
   assign latchWe = (take && reqOp == PFA_OP_WRITE) ? reqLanes : PFA_LANE_NONE;

   // Array is written only by program or erase sequences
   always_comb begin
      arrWe = PFA_LANE_NONE;
      arrWaddr = baseQ | AW'(cntQ);
      arrWdata = PFA_ERASED_WORD;
      if (stateQ == PFA_ST_PROG) begin
         if (cntQ != '0) begin
            arrWe = PFA_LANE_ALL;
         end
         arrWaddr = baseQ | AW'(cntQ - CW'(1));
         arrWdata = latchRd;
      end else if (stateQ == PFA_ST_ERASE) begin
         arrWe = PFA_LANE_ALL;
      end
   end

   pfa_mem #(.LANES(PFA_LANES), .LANE_W(PFA_LANE_W), .DEPTH(PFA_ROW_WORDS)) uLatch (
      .clk(ref_clk),
      .rst_n(rst_n),
      .we(latchWe),
      .waddr(wordIdx[LW-1:0]),
      .wdata(reqData),
      .raddr(cntQ[LW-1:0]),
      .rdata(latchRd)
   );

   pfa_mem #(.LANES(PFA_LANES), .LANE_W(PFA_LANE_W), .DEPTH(ARRAY_WORDS)) uArray (
      .clk(ref_clk),
      .rst_n(rst_n),
      .we(arrWe),
      .waddr(arrWaddr),
      .wdata(arrWdata),
      .raddr(wordIdx),
      .rdata(arrRd)
   );

   // Read format kept for the cycle the array answers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdSerQ <= 1'b0;
         rdHighQ <= 1'b0;
         rdByteQ <= 1'b0;
         rdOddQ <= 1'b0;
      end else if (take) begin
         rdSerQ <= serPendQ;
         rdHighQ <= tblReq.high;
         rdByteQ <= tblReq.byteMode;
         rdOddQ <= tblReq.ea[0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tblRspQ <= '0;
      end else begin
         tblRspQ.valid <= (stateQ == PFA_ST_READ) && !rdSerQ;
         if (stateQ == PFA_ST_READ && !rdSerQ) begin
            if (!rdHighQ) begin
               tblRspQ.data <= rdByteQ ? {8'h00, rdOddQ ? arrRd[15:8] : arrRd[7:0]} : arrRd[15:0];
            end else begin
               // bits 23:16, phantom byte reads zero
               tblRspQ.data <= (rdByteQ && rdOddQ) ? 16'h0000 : {8'h00, arrRd[23:16]};
            end
         end
      end
   end

   // Core handshake and status, all registered
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tblReadyQ <= 1'b0;
         busyQ <= 1'b0;
         opDoneQ <= 1'b0;
      end else begin
         // Core is locked out while the programmer holds master clear
         // One refused cycle after every take, so writes pace at two cycles
         tblReadyQ <= (stateD == PFA_ST_IDLE) && mclrN && !frameDone && !take && !serPendQ;
         busyQ <= (stateD == PFA_ST_PROG) || (stateD == PFA_ST_ERASE);
         opDoneQ <= (stateQ != stateD) && (stateD == PFA_ST_IDLE) && (stateQ != PFA_ST_READ);
      end
   end

   // programmer clock edge, master clear held low
   assign pgRise = pgClk && !pgClkQ && !mclrN;
   assign frameDone = pgRise && (outCntQ == '0) && (serCntQ == PFA_FRAME_LAST);

   // Frame shifter; idle while read-back is being driven
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pgClkQ <= 1'b0;
         serCntQ <= '0;
         serShiftQ <= '0;
         serFrameQ <= '0;
      end else begin
         pgClkQ <= pgClk;
         if (mclrN) begin
            serCntQ <= '0;
         end else if (pgRise && outCntQ == '0) begin
            serShiftQ <= {serShiftQ[PFA_FRAME_BITS-2:0], pgDataIn};
            serCntQ <= frameDone ? 6'h00 : serCntQ + 6'h01;
            if (frameDone) begin
               serFrameQ <= pfa_ser_frame_t'({serShiftQ[PFA_FRAME_BITS-2:0], pgDataIn});
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serPendQ <= 1'b0;
      end else if (frameDone) begin
         serPendQ <= 1'b1;
      end else if (take) begin
         serPendQ <= 1'b0;
      end
   end

   // Read-back: MSB first, next bit after each rising programmer clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outShiftQ <= '0;
         outCntQ <= '0;
         pgDataOutQ <= 1'b0;
         pgDataOeQ <= 1'b0;
      end else if (mclrN) begin
         outCntQ <= '0;
         pgDataOeQ <= 1'b0;
      end else if (stateQ == PFA_ST_READ && rdSerQ) begin
         outShiftQ <= arrRd;
         outCntQ <= PFA_READBACK_BITS;
         pgDataOutQ <= arrRd[PFA_WORD_W-1];
         pgDataOeQ <= 1'b1;
      end else if (pgRise && outCntQ != '0) begin
         outShiftQ <= {outShiftQ[PFA_WORD_W-2:0], 1'b0};
         outCntQ <= outCntQ - 5'h01;
         pgDataOutQ <= outShiftQ[PFA_WORD_W-2];
         pgDataOeQ <= (outCntQ != 5'h01);
      end
   end

   assign tblReady = tblReadyQ;
   assign tblRsp = tblRspQ;
   assign busy = busyQ;
   assign opDone = opDoneQ;
   assign pgDataOut = pgDataOutQ;
   assign pgDataOe = pgDataOeQ;
endmodule : pfa_table_access
`default_nettype wire

// file: pfa_pkg.sv
`default_nettype none
package pfa_pkg;
   // Table address and data widths
   localparam int PFA_ADDR_W = 24;
   localparam int PFA_PAGE_W = 8;
   localparam int PFA_EA_W = 16;
   localparam int PFA_DATA_W = 16;
   localparam int PFA_LANE_W = 8;
   localparam int PFA_LANES = 3;
   localparam int PFA_WORD_W = PFA_LANE_W * PFA_LANES;
   // Self-programming block sizes, in instructions
   localparam int PFA_ROW_WORDS = 64;
   localparam int PFA_ERASE_WORDS = 512;
   // Default size of the modelled array, a whole number of erase blocks
   localparam int PFA_ARRAY_WORDS_DFLT = 2048;
   localparam logic [23:0] PFA_ERASED_WORD = 24'hFFFFFF;
   // Byte lane enables of one program word
   localparam logic [2:0] PFA_LANE_NONE = 3'h0;
   localparam logic [2:0] PFA_LANE_B0 = 3'h1;
   localparam logic [2:0] PFA_LANE_B1 = 3'h2;
   localparam logic [2:0] PFA_LANE_LOW = 3'h3;
   localparam logic [2:0] PFA_LANE_HIGH = 3'h4;
   localparam logic [2:0] PFA_LANE_ALL = 3'h7;
   // Serial frame: op, 24-bit address, 24-bit data, MSB first
   localparam int PFA_FRAME_BITS = 50;
   localparam logic [5:0] PFA_FRAME_LAST = 6'h31;
   localparam logic [4:0] PFA_READBACK_BITS = 5'h18;

   typedef enum logic [1:0] {
      PFA_OP_READ = 2'b00,
      PFA_OP_WRITE = 2'b01,
      PFA_OP_PROG = 2'b10,
      PFA_OP_ERASE = 2'b11
   } pfa_op_t;

   typedef enum logic [1:0] {
      PFA_ST_IDLE = 2'b00,
      PFA_ST_READ = 2'b01,
      PFA_ST_PROG = 2'b10,
      PFA_ST_ERASE = 2'b11
   } pfa_state_t;

   typedef struct packed {
      logic valid;
      pfa_op_t op;
      logic high;
      logic byteMode;
      logic [PFA_PAGE_W-1:0] page;
      logic [PFA_EA_W-1:0] ea;
      logic [PFA_DATA_W-1:0] wdata;
   } pfa_tbl_req_t;

   typedef struct packed {
      logic valid;
      logic [PFA_DATA_W-1:0] data;
   } pfa_tbl_rsp_t;

   typedef struct packed {
      pfa_op_t op;
      logic [PFA_ADDR_W-1:0] addr;
      logic [PFA_WORD_W-1:0] data;
   } pfa_ser_frame_t;
endpackage : pfa_pkg
`default_nettype wire

// file: pfa_mem.sv
`timescale 1ns/1ps
`default_nettype none
module pfa_mem #(
   parameter int LANES = 3,
   parameter int LANE_W = 8,
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [LANES-1:0] we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [LANES*LANE_W-1:0] wdata,
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [LANES*LANE_W-1:0] rdata
);
   logic [LANES*LANE_W-1:0] mem [DEPTH];

   // Byte-lane writes; no reset so it maps to RAM
   always_ff @(posedge clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (we[i]) begin
            mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
         end
      end
   end

   // Registered read, one cycle of latency
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : pfa_mem
`default_nettype wire

// file: pfa_table_access_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pfa_table_access_chk
   import pfa_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire pfa_tbl_req_t tblReq,
   input wire logic tblReady,
   input wire pfa_tbl_rsp_t tblRsp,
   input wire logic busy,
   input wire logic opDone,
   input wire logic mclrN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Core request accepted at this edge
   logic take;
   assign take = tblReq.valid && tblReady;
   a_read_latency: assert property (take && tblReq.op == PFA_OP_READ |-> ##2 tblRsp.valid)
      else $error("late read answer");
   a_ready_drop: assert property (take |=> !tblReady)
      else $error("ready after take");
   a_busy_block: assert property (busy |-> !tblReady)
      else $error("ready while busy");
   a_prog_count: assert property (take && tblReq.op == PFA_OP_PROG |-> ##66 opDone)
      else $error("program length wrong");
   a_prog_busy: assert property (take && tblReq.op == PFA_OP_PROG |=> busy [*8])
      else $error("busy missing");
   a_erase_count: assert property (take && tblReq.op == PFA_OP_ERASE |-> ##[513:513] opDone)
      else $error("erase length wrong");
   a_done_pulse: assert property (opDone |=> !opDone)
      else $error("done too long");
   a_rsp_pulse: assert property (tblRsp.valid |=> !tblRsp.valid)
      else $error("answer too long");
   a_clear_refuse: assert property (!mclrN ##1 !mclrN |=> !tblReady)
      else $error("ready in programming mode");
   // Main traffic seen
   c_erase: cover property (take && tblReq.op == PFA_OP_ERASE);
   c_done: cover property (opDone);
   c_read: cover property (take && tblReq.op == PFA_OP_READ);
endmodule : pfa_table_access_chk
bind pfa_table_access pfa_table_access_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .tblReq(tblReq),
   .tblReady(tblReady), .tblRsp(tblRsp), .busy(busy), .opDone(opDone), .mclrN(mclrN));
`default_nettype wire

// file: pfa_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfa_prog_model (
   input wire logic ref_clk,
   input wire logic pgDataOut,
   input wire logic pgDataOe,
   output logic pgClk,
   output logic pgDataIn,
   output logic mclrN
);
   // Idle link: clock parked low, device running
   initial begin
      pgClk = 1'b0;
      pgDataIn = 1'b1;
      mclrN = 1'b1;
   end
   task automatic set_clear(input logic v);
      @(posedge ref_clk);
      mclrN <= v;
   endtask : set_clear
   // two cycles per phase, slow enough for the sampler
   task automatic pulse();
      @(posedge ref_clk);
      pgClk <= 1'b1;
      repeat (2) @(posedge ref_clk);
      pgClk <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : pulse
   task automatic send(input logic [49:0] f);
      // Start off the edge so the data line never changes twice in one step
      @(negedge ref_clk);
      for (int i = 49; i >= 0; i--) begin
         pgDataIn <= f[i];
         pulse();
      end
      // Undriven line shows the inverse, never a held level
      pgDataIn <= ~f[0];
   endtask : send
   // bits clocked back from the device
   task automatic readback(output logic [23:0] v);
      int n;
      n = 0;
      v = 'x;
      @(negedge ref_clk);
      while (pgDataOe !== 1'b1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      // No answer: leave the word unknown for the bench to reject
      if (pgDataOe !== 1'b1) begin
         return;
      end
      for (int i = 23; i >= 0; i--) begin
         v[i] = pgDataOut;
         pulse();
         repeat (3) @(negedge ref_clk);
      end
   endtask : readback
endmodule : pfa_prog_model
`default_nettype wire

// file: pfa_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import pfa_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   pfa_tbl_req_t tblReq = '0;
   pfa_tbl_rsp_t tblRsp;
   logic tblReady, busy, opDone, pgClk, pgDataIn, pgDataOut, pgDataOe, mclrN;
   logic [15:0] rd;
   int err_count = 0;
   int compares = 0;
   // 20 MHz system clock
   always #25 ref_clk = ~ref_clk;
   // Small array of two erase blocks; each erase still steps 512 words
   pfa_table_access #(.ARRAY_WORDS(1024)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .tblReq(tblReq),
      .tblReady(tblReady), .tblRsp(tblRsp), .busy(busy), .opDone(opDone), .pgClk(pgClk), .pgDataIn(pgDataIn),
      .pgDataOut(pgDataOut), .pgDataOe(pgDataOe), .mclrN(mclrN));
   pfa_prog_model prog (.ref_clk(ref_clk), .pgDataOut(pgDataOut), .pgDataOe(pgDataOe), .pgClk(pgClk),
      .pgDataIn(pgDataIn), .mclrN(mclrN));
   task automatic final_report();
      $display("compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One table operation; m is {high, byteMode}; a stuck wait ends the run
   task automatic core_op(input pfa_op_t op, input logic [1:0] m, input logic [15:0] ea, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      tblReq <= '{1'b1, op, m[1], m[0], 8'h00, ea, wd};
      do begin
         @(negedge ref_clk);
         n++;
      end while (tblReady !== 1'b1 && n < 40);
      if (tblReady !== 1'b1) begin
         chk(24'h0, 24'h1);
         final_report();
      end
      @(posedge ref_clk);
      tblReq.valid <= 1'b0;
      rd = 'x;
      if (op == PFA_OP_READ) begin
         repeat (2) @(negedge ref_clk);
         chk({23'h0, tblRsp.valid}, 24'h1);
         rd = tblRsp.data;
      end else if (op == PFA_OP_PROG || op == PFA_OP_ERASE) begin
         n = 0;
         @(negedge ref_clk);
         chk({23'h0, busy}, 24'h1);
         while (opDone !== 1'b1 && n < 600) begin
            @(negedge ref_clk);
            n++;
         end
         chk({23'h0, opDone}, 24'h1);
         chk({23'h0, busy}, 24'h0);
         if (opDone !== 1'b1) begin
            final_report();
         end
      end
   endtask : core_op
   task automatic test_core();
      logic [15:0] ea [8] = '{16'h0480, 16'h0480, 16'h0481, 16'h0480, 16'h0481, 16'h0483, 16'h0400, 16'h0500};
      logic [1:0] md [8] = '{2'b00, 2'b10, 2'b01, 2'b01, 2'b11, 2'b01, 2'b00, 2'b00};
      logic [15:0] ex [8] = '{16'h1234, 16'h00AB, 16'h0012, 16'h0034, 16'h0000, 16'h005A, 16'hFFFF, 16'hFFFF};
      core_op(PFA_OP_ERASE, 2'b00, 16'h0402, 16'h0000);
      core_op(PFA_OP_READ, 2'b10, 16'h0480, 16'h0000);
      chk({8'h00, rd}, 24'h0000FF);
      core_op(PFA_OP_WRITE, 2'b00, 16'h0480, 16'h1234);
      core_op(PFA_OP_WRITE, 2'b10, 16'h0480, 16'h00AB);
      core_op(PFA_OP_WRITE, 2'b01, 16'h0483, 16'h005A);
      core_op(PFA_OP_READ, 2'b00, 16'h0480, 16'h0000);
      chk({8'h00, rd}, 24'h00FFFF);
      core_op(PFA_OP_PROG, 2'b00, 16'h04BE, 16'h0000);
      // Words, bytes, phantom byte, and neighbours outside the block
      for (int i = 0; i < 8; i++) begin
         core_op(PFA_OP_READ, md[i], ea[i], 16'h0000);
         chk({8'h00, rd}, {8'h00, ex[i]});
      end
      $display("core test done");
   endtask : test_core
   task automatic test_serial();
      logic [23:0] sv;
      prog.set_clear(1'b0);
      repeat (3) @(negedge ref_clk);
      chk({23'h0, tblReady}, 24'h0);
      prog.send({PFA_OP_ERASE, 24'h000002, 24'h000000});
      repeat (520) @(posedge ref_clk);
      prog.send({PFA_OP_WRITE, 24'h000000, 24'h3C5A69});
      prog.send({PFA_OP_PROG, 24'h000004, 24'h000000});
      repeat (520) @(posedge ref_clk);
      prog.send({PFA_OP_READ, 24'h000000, 24'h000000});
      prog.readback(sv);
      chk(sv, 24'h3C5A69);
      if ($isunknown(sv)) begin
         final_report();
      end
      prog.send({PFA_OP_READ, 24'h000080, 24'h000000});
      prog.readback(sv);
      chk(sv, 24'hFFFFFF);
      if ($isunknown(sv)) begin
         final_report();
      end
      repeat (4) @(negedge ref_clk);
      chk({23'h0, pgDataOe}, 24'h0);
      prog.set_clear(1'b1);
      core_op(PFA_OP_READ, 2'b10, 16'h0000, 16'h0000);
      chk({8'h00, rd}, 24'h00003C);
      $display("serial test done");
   endtask : test_serial
   // Reset, then core and programmer traffic
   initial begin
      repeat (20) @(posedge ref_clk);
      chk({19'h0, busy, opDone, tblReady, tblRsp.valid, pgDataOe}, 24'h0);
      rst_n <= 1'b1;
      test_core();
      test_serial();
      final_report();
   end
endmodule : tb
`default_nettype wire
